// *** logic/meb_pkg.sv ***
`default_nettype none
// ----------------------------------------------------------------------------
// constants for the motion engine register bank
// ----------------------------------------------------------------------------
package meb_pkg;

  // bus geometry: word address, one register per 32-bit word
  localparam int ADDR_W  = 7;
  localparam int DATA_W  = 32;
  localparam int ENGINES = 16;

  // register indices, byte address is four times the index
  localparam logic [6:0] IDX_PAGE_SEL = 7'h02;
  localparam logic [6:0] IDX_ROUTE_A  = 7'h0F;
  localparam logic [6:0] IDX_ROUTE_B  = 7'h10;
  localparam logic [6:0] IDX_STAT_A   = 7'h13;
  localparam logic [6:0] IDX_STAT_B   = 7'h14;
  localparam logic [6:0] IDX_PAGE_RW  = 7'h17;
  localparam logic [6:0] IDX_BATCH    = 7'h44;
  localparam logic [6:0] IDX_EN_A     = 7'h46;
  localparam logic [6:0] IDX_EN_B     = 7'h47;
  localparam logic [6:0] IDX_LC_L     = 7'h48;
  localparam logic [6:0] IDX_LC_H     = 7'h49;
  localparam logic [6:0] IDX_LC_CLR   = 7'h4A;
  localparam logic [6:0] IDX_OUTS1    = 7'h4C;
  localparam logic [6:0] IDX_OUTS2    = 7'h4D;
  localparam logic [6:0] IDX_OUTS3    = 7'h4E;
  localparam logic [6:0] IDX_GLOBAL   = 7'h5F;

  // field positions
  localparam int BIT_LATCH    = 7;
  localparam int BIT_PWRITE   = 6;
  localparam int BIT_PREAD    = 5;
  localparam int BIT_BATCH    = 6;
  localparam int BIT_LC_DONE  = 1;
  localparam int BIT_LC_REQ   = 0;
  localparam int BIT_GLOBAL   = 1;
  localparam int PAGE_SEL_W   = 4;

  // reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [31:0] RST_WORD  = 32'h00000000;

  // bus answer states, gray along idle -> ack -> idle
  typedef enum logic [1:0] {
    MEB_IDLE = 2'b00,
    MEB_ACK  = 2'b01
  } meb_bus_state_t;

endpackage : meb_pkg
`default_nettype wire

// *** logic/meb_top.sv ***
// How it works
// - high status byte flags pending events of engines 9 to 16.
// - latch mode 0 pulses the irq, 1 holds it until status read; resets 0.
// - page writes pass only while page write enable is 1; resets 0.
// - page reads pass only while page read enable is 1; resets 0.
// - page accesses use the four-bit page select at index 02h.
// - batching enable pushes step counter values into the fifo; resets 0.
// - each engine runs only while its enable bit is 1; resets 0.
// - long counter is an unsigned 16-bit value over two byte registers.
// - low counter register shows bits 7 to 0, resets zero.
// - high counter register shows bits 15 to 8, resets zero.
// - setting the clear request bit zeroes the long counter.
// - device sets clear-done after the counter clear; software cannot write it.
// - engine output byte holds eight axis and vector event flags.
// - vector flags report magnitude events apart from axis flags.
// - engine 1 to 3 output bytes sit at 4Ch, 4Dh, 4Eh.
// - second irq pin is the OR of routed engine events.
// - routing counts only while the global route bit is 1.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module meb_top (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [meb_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [meb_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic                         avs_waitrequest,
  output logic [meb_pkg::DATA_W-1:0]   avs_readdata,
  input  wire logic [15:0]             engine_event,
  input  wire logic [7:0]              engine1_outs,
  input  wire logic [7:0]              engine2_outs,
  input  wire logic [7:0]              engine3_outs,
  input  wire logic                    long_count_tick,
  input  wire logic                    step_count_valid,
  input  wire logic [15:0]             step_count_value,
  input  wire logic                    page_wr_req,
  input  wire logic                    page_rd_req,
  output logic [15:0]                  engine_enable,
  output logic [3:0]                   page_select,
  output logic                         page_wr_go,
  output logic                         page_rd_go,
  output logic                         fifo_push,
  output logic [15:0]                  fifo_data,
  output logic                         second_irq_pin
);
  import meb_pkg::*;

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_n;

  // async assert, release after two edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // --------------------------------------------------------------------------
  // bus slave handshake
  // --------------------------------------------------------------------------
  meb_bus_state_t state_q;
  logic           wait_q;
  logic [31:0]    rdata_q;
  logic [31:0]    rdata_d;
  logic           rd_take;
  logic           wr_commit;
  logic [7:0]     wbyte;

  // read data is captured at the first edge, write lands at the second
  assign rd_take   = avs_read && (state_q == MEB_IDLE);
  assign wr_commit = avs_write && (state_q == MEB_ACK) && avs_byteenable[0];
  assign wbyte     = avs_writedata[7:0];
  // one answer per request, waitrequest drops for exactly one cycle
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= MEB_IDLE;
      wait_q  <= 1'b1;
      rdata_q <= RST_WORD;
    end else begin
      case (state_q)
        MEB_IDLE: begin
          if (avs_read || avs_write) begin
            state_q <= MEB_ACK;
            wait_q  <= 1'b0;
            rdata_q <= avs_read ? rdata_d : RST_WORD;
          end
        end
        MEB_ACK: begin
          state_q <= MEB_IDLE;
          wait_q  <= 1'b1;
        end
        default: begin
          state_q <= MEB_IDLE;
          wait_q  <= 1'b1;
        end
      endcase
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  a_bus_answer: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer not one cycle after request");

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  logic [3:0]  page_sel_q;
  logic [7:0]  route_a_q;
  logic [7:0]  route_b_q;
  logic        global_q;
  logic        latch_q;
  logic        pwrite_q;
  logic        pread_q;
  logic        batch_q;
  logic [15:0] en_q;

  // reserved bits are dropped on write so they always read zero
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      page_sel_q <= RST_BYTE[3:0];
      route_a_q  <= RST_BYTE;
      route_b_q  <= RST_BYTE;
      global_q   <= RST_BYTE[0];
      latch_q    <= RST_BYTE[0];
      pwrite_q   <= RST_BYTE[0];
      pread_q    <= RST_BYTE[0];
      batch_q    <= RST_BYTE[0];
      en_q       <= RST_COUNT;
    end else if (wr_commit) begin
      case (avs_address)
        IDX_PAGE_SEL: page_sel_q <= wbyte[PAGE_SEL_W-1:0];
        IDX_ROUTE_A:  route_a_q  <= wbyte;
        IDX_ROUTE_B:  route_b_q  <= wbyte;
        IDX_GLOBAL:   global_q   <= wbyte[BIT_GLOBAL];
        IDX_PAGE_RW: begin
          latch_q  <= wbyte[BIT_LATCH];
          pwrite_q <= wbyte[BIT_PWRITE];
          pread_q  <= wbyte[BIT_PREAD];
        end
        IDX_BATCH:    batch_q    <= wbyte[BIT_BATCH];
        IDX_EN_A:     en_q[7:0]  <= wbyte;
        IDX_EN_B:     en_q[15:8] <= wbyte;
        default: begin
        end
      endcase
    end
  end

  assign engine_enable = en_q;
  assign page_select   = page_sel_q;

  // --------------------------------------------------------------------------
  // advanced page gating
  // --------------------------------------------------------------------------
  logic page_wr_q;
  logic page_rd_q;

  // a disabled page simply never sees the access
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      page_wr_q <= 1'b0;
      page_rd_q <= 1'b0;
    end else begin
      page_wr_q <= page_wr_req && pwrite_q;
      page_rd_q <= page_rd_req && pread_q;
    end
  end

  assign page_wr_go = page_wr_q;
  assign page_rd_go = page_rd_q;
  a_page_wr_gate: assert property (@(posedge clock) disable iff (!rst_sync_n)
    page_wr_go |-> $past(page_wr_req) && $past(pwrite_q))
    else $error("page write passed while disabled");
  a_page_rd_gate: assert property (@(posedge clock) disable iff (!rst_sync_n)
    page_rd_req && !pread_q |=> !page_rd_go)
    else $error("page read passed while disabled");

  // --------------------------------------------------------------------------
  // step counter batching
  // --------------------------------------------------------------------------
  logic        push_q;
  logic [15:0] fdata_q;

  // value is held between pushes so the fifo may sample late
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      push_q  <= 1'b0;
      fdata_q <= RST_COUNT;
    end else begin
      push_q <= step_count_valid && batch_q;
      if (step_count_valid && batch_q) begin
        fdata_q <= step_count_value;
      end
    end
  end

  assign fifo_push = push_q;
  assign fifo_data = fdata_q;
  a_batch_push: assert property (@(posedge clock) disable iff (!rst_sync_n)
    step_count_valid && batch_q |=> fifo_push && fifo_data == $past(step_count_value))
    else $error("step value not pushed");

  // --------------------------------------------------------------------------
  // engine events and pending flags
  // --------------------------------------------------------------------------
  logic [15:0] ev_gated;
  logic [15:0] pend_q;
  logic [15:0] pend_clr;

  // a disabled engine raises nothing
  assign ev_gated = engine_event & en_q;
  // status reads clear their byte; an event in that cycle still lands
  assign pend_clr = {{8{rd_take && avs_address == IDX_STAT_B}},
                     {8{rd_take && avs_address == IDX_STAT_A}}};

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pend_q <= RST_COUNT;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | ev_gated;
    end
  end
  a_status_set: assert property (@(posedge clock) disable iff (!rst_sync_n)
    engine_event[12] && en_q[12] |=> pend_q[12])
    else $error("engine event lost from status");

  // --------------------------------------------------------------------------
  // second irq pin
  // --------------------------------------------------------------------------
  logic [15:0] route;
  logic        irq_q;

  assign route = {route_b_q, route_a_q};

  // pulse mode follows enabled events, latch mode follows pending flags
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_q <= 1'b0;
    end else if (latch_q) begin
      irq_q <= global_q && |(pend_q & route);
    end else begin
      irq_q <= global_q && |(ev_gated & route);
    end
  end

  assign second_irq_pin = irq_q;
  a_irq_global: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !global_q |=> !second_irq_pin)
    else $error("irq raised with global route off");
  a_irq_pulse: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !latch_q && global_q |=> second_irq_pin == |($past(ev_gated) & $past(route)))
    else $error("pulse mode irq mismatch");
  a_irq_latch: assert property (@(posedge clock) disable iff (!rst_sync_n)
    latch_q && global_q |=> second_irq_pin == |($past(pend_q) & $past(route)))
    else $error("latched irq mismatch");

  // --------------------------------------------------------------------------
  // engine output flags
  // --------------------------------------------------------------------------
  logic [2:0][7:0] outs_in;
  logic [7:0]      outs_q [0:2]; // unpacked: each generated process owns one entry

  assign outs_in = {engine3_outs, engine2_outs, engine1_outs};

  // bit7..0: +x -x +y -y +z -z +vector -vector, frozen while disabled
  for (genvar g = 0; g < 3; g++) begin : g_outs
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        outs_q[g] <= RST_BYTE;
      end else if (en_q[g]) begin
        outs_q[g] <= outs_in[g];
      end
    end
  end
  a_outs_hold: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !en_q[0] && avs_write |=> $stable(outs_q[0]))
    else $error("engine 1 flags changed while disabled");

  // --------------------------------------------------------------------------
  // long counter with clear handshake
  // --------------------------------------------------------------------------
  logic [15:0] lc_q;
  logic        lc_req_q;
  logic        lc_done_q;
  logic        lc_wr_req;

  assign lc_wr_req = wr_commit && (avs_address == IDX_LC_CLR) && wbyte[BIT_LC_REQ];

  // clear takes one cycle; the done flag is hardware-owned
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lc_q      <= RST_COUNT;
      lc_req_q  <= 1'b0;
      lc_done_q <= 1'b0;
    end else begin
      if (lc_req_q) begin
        lc_q <= RST_COUNT;
      end else if (long_count_tick) begin
        lc_q <= lc_q + 16'h0001;
      end
      // a new write request wins over the return to zero
      lc_req_q <= lc_wr_req ? 1'b1 : 1'b0;
      if (lc_req_q) begin
        lc_done_q <= 1'b1;
      end else if (lc_wr_req) begin
        lc_done_q <= 1'b0;
      end
    end
  end
  a_count_clear: assert property (@(posedge clock) disable iff (!rst_sync_n)
    lc_req_q |=> lc_q == 16'h0000 && lc_done_q)
    else $error("long counter not cleared");
  a_req_return: assert property (@(posedge clock) disable iff (!rst_sync_n)
    lc_req_q && !lc_wr_req |=> !lc_req_q)
    else $error("clear request stuck");
  a_count_step: assert property (@(posedge clock) disable iff (!rst_sync_n)
    long_count_tick && !lc_req_q |=> lc_q == $past(lc_q) + 16'h0001)
    else $error("long counter did not advance");

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  // unmapped indices read zero; read-only ones ignore writes
  always_comb begin
    rdata_d = RST_WORD;
    case (avs_address)
      IDX_PAGE_SEL: rdata_d[3:0] = page_sel_q;
      IDX_ROUTE_A:  rdata_d[7:0] = route_a_q;
      IDX_ROUTE_B:  rdata_d[7:0] = route_b_q;
      IDX_GLOBAL:   rdata_d[BIT_GLOBAL] = global_q;
      IDX_STAT_A:   rdata_d[7:0] = pend_q[7:0];
      IDX_STAT_B:   rdata_d[7:0] = pend_q[15:8];
      IDX_PAGE_RW: begin
        rdata_d[BIT_LATCH]  = latch_q;
        rdata_d[BIT_PWRITE] = pwrite_q;
        rdata_d[BIT_PREAD]  = pread_q;
      end
      IDX_BATCH:    rdata_d[BIT_BATCH] = batch_q;
      IDX_EN_A:     rdata_d[7:0] = en_q[7:0];
      IDX_EN_B:     rdata_d[7:0] = en_q[15:8];
      IDX_LC_L:     rdata_d[7:0] = lc_q[7:0];
      IDX_LC_H:     rdata_d[7:0] = lc_q[15:8];
      IDX_LC_CLR: begin
        rdata_d[BIT_LC_DONE] = lc_done_q;
        rdata_d[BIT_LC_REQ]  = lc_req_q;
      end
      IDX_OUTS1:    rdata_d[7:0] = outs_q[0];
      IDX_OUTS2:    rdata_d[7:0] = outs_q[1];
      IDX_OUTS3:    rdata_d[7:0] = outs_q[2];
      default:      rdata_d = RST_WORD;
    endcase
  end

endmodule // meb_top
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import meb_pkg::*;
  // --------------------------------------------------------------
  // signals and the behavioural copy of the bank
  // --------------------------------------------------------------
  logic        clock;
  logic        rst_n;
  logic [6:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic        avs_waitrequest;
  logic [31:0] avs_readdata;
  logic [15:0] engine_event;
  logic [7:0]  engine1_outs;
  logic [7:0]  engine2_outs;
  logic [7:0]  engine3_outs;
  logic        long_count_tick;
  logic        step_count_valid;
  logic [15:0] step_count_value;
  logic        page_wr_req;
  logic        page_rd_req;
  logic [15:0] engine_enable;
  logic [3:0]  page_select;
  logic        page_wr_go;
  logic        page_rd_go;
  logic        fifo_push;
  logic [15:0] fifo_data;
  logic        second_irq_pin;
  int          error_cnt;
  int          n_checks;
  int          n;
  logic [31:0] q;
  logic [7:0]  r;
  logic [7:0]  mdl [0:127];  // expected register contents
  logic [7:0]  msk [0:127];  // writable bits, zero for read-only places
  localparam logic [6:0] RIX [0:9] = '{7'h02, 7'h17, 7'h44, 7'h46, 7'h47,
                                       7'h48, 7'h49, 7'h4A, 7'h14, 7'h7F};
  localparam logic [6:0] WIX [0:7] = '{7'h02, 7'h17, 7'h44, 7'h46, 7'h47,
                                       7'h0F, 7'h10, 7'h5F};

  // byteenable tied full: every write here is a whole-byte write
  meb_top meb_top_i (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .engine_event(engine_event), .engine1_outs(engine1_outs),
    .engine2_outs(engine2_outs), .engine3_outs(engine3_outs),
    .long_count_tick(long_count_tick), .step_count_valid(step_count_valid),
    .step_count_value(step_count_value), .page_wr_req(page_wr_req),
    .page_rd_req(page_rd_req), .engine_enable(engine_enable),
    .page_select(page_select), .page_wr_go(page_wr_go), .page_rd_go(page_rd_go),
    .fifo_push(fifo_push), .fifo_data(fifo_data), .second_irq_pin(second_irq_pin));

  // free-running 100 MHz clock
  initial clock = 1'b0;
  always #5 clock = ~clock;

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // one bus cycle; holds everything until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d);
    int k;
    k = 0;
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      $display("[FAIL] bus answer expected ack seen timeout");
      stop_test();
    end
    // one idle edge, so no request signal is driven twice in a step
    @(posedge clock);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    mdl[a] = d & msk[a];
  endtask

  task automatic rd(input string nm, input logic [6:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h000000, e}, q);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {avs_read, avs_write, page_wr_req, page_rd_req} = 4'h0;
    {long_count_tick, step_count_valid} = 2'b00;
    avs_address      = 7'h00;
    avs_writedata    = 32'h00000000;
    engine_event     = 16'h0000;
    step_count_value = 16'h0000;
    engine1_outs     = 8'h00;
    engine2_outs     = 8'h00;
    engine3_outs     = 8'h00;
    rst_n            = 1'b0;
    error_cnt        = 0;
    n_checks         = 0;
    foreach (mdl[i]) begin
      mdl[i] = 8'h00;
      msk[i] = 8'h00;
    end
    msk[7'h02] = 8'h0F;
    msk[7'h17] = 8'hE0;
    msk[7'h44] = 8'h40;
    msk[7'h46] = 8'hFF;
    msk[7'h47] = 8'hFF;
    msk[7'h0F] = 8'hFF;
    msk[7'h10] = 8'hFF;
    msk[7'h5F] = 8'h02;
    void'($urandom(32'h44D2));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    // reset values, unmapped place ignores writes
    bus(1'b1, 7'h7F, 8'hFF);
    for (int i = 0; i < 10; i++) rd("reset value", RIX[i], 8'h00);
    chk("enable reset", 32'h0, 32'(engine_enable));
    $display("test reset done");
    // random legal values, reserved bits kept zero by software
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 8; i++) begin
        wr(WIX[i], 8'($urandom) & msk[WIX[i]]);
        rd("readback", WIX[i], mdl[WIX[i]]);
      end
      chk("engine_enable", {16'h0, mdl[7'h47], mdl[7'h46]}, 32'(engine_enable));
      chk("page_select", 32'(mdl[7'h02][3:0]), 32'(page_select));
    end
    $display("test readback done");
    // long counter past the byte boundary, then the clear handshake
    n = 256 + int'($urandom % 200);
    long_count_tick <= 1'b1;
    repeat (n) @(posedge clock);
    long_count_tick <= 1'b0;
    @(posedge clock);
    rd("count low", 7'h48, n[7:0]);
    rd("count high", 7'h49, n[15:8]);
    wr(7'h4A, 8'h01);
    rd("clear ctrl", 7'h4A, 8'h02);
    rd("count low", 7'h48, 8'h00);
    rd("count high", 7'h49, 8'h00);
    wr(7'h4A, 8'h00);
    rd("done kept", 7'h4A, 8'h02);
    $display("test long counter done");
    // page gate under every enable pair
    for (int i = 0; i < 4; i++) begin
      wr(7'h17, 8'(i << 5));
      page_wr_req <= 1'b1;
      page_rd_req <= 1'b1;
      @(posedge clock);
      page_wr_req <= 1'b0;
      page_rd_req <= 1'b0;
      @(negedge clock);
      chk("page_wr_go", 32'(i >> 1), 32'(page_wr_go));
      chk("page_rd_go", 32'(i & 1), 32'(page_rd_go));
      @(posedge clock);
    end
    $display("test page gate done");
    // step batching off, then on
    for (int i = 0; i < 2; i++) begin
      wr(7'h44, 8'(i << 6));
      step_count_valid <= 1'b1;
      step_count_value <= 16'($urandom);
      @(posedge clock);
      step_count_valid <= 1'b0;
      @(negedge clock);
      chk("fifo_push", 32'(i), 32'(fifo_push));
      if (i == 1) chk("fifo_data", 32'(step_count_value), 32'(fifo_data));
      @(posedge clock);
    end
    $display("test batching done");
    // flag bytes follow while enabled and hold once disabled
    wr(7'h46, 8'h07);
    engine1_outs <= 8'($urandom);
    engine2_outs <= 8'($urandom);
    engine3_outs <= 8'($urandom);
    repeat (2) @(posedge clock);
    wr(7'h46, 8'h00);
    engine1_outs <= ~engine1_outs;
    engine2_outs <= ~engine2_outs;
    engine3_outs <= ~engine3_outs;
    bus(1'b1, 7'h4C, 8'h00);
    rd("outs1", 7'h4C, ~engine1_outs);
    rd("outs2", 7'h4D, ~engine2_outs);
    rd("outs3", 7'h4E, ~engine3_outs);
    $display("test flag bytes done");
    // latched status; engine 16 and engines 1 to 8 are off, so their events drop
    wr(7'h17, 8'h80);
    wr(7'h47, 8'h7F);
    wr(7'h10, 8'hFF);
    wr(7'h5F, 8'h02);
    r = 8'($urandom) | 8'h11;
    engine_event <= {r, ~r};
    @(posedge clock);
    engine_event <= 16'h0000;
    repeat (2) @(posedge clock);
    chk("irq latched", 32'h1, 32'(second_irq_pin));
    bus(1'b1, 7'h14, 8'h00);
    rd("status high", 7'h14, r & 8'h7F);
    rd("status low", 7'h13, 8'h00);
    rd("status cleared", 7'h14, 8'h00);
    chk("irq released", 32'h0, 32'(second_irq_pin));
    // pulse mode, global route on and then off
    wr(7'h17, 8'h00);
    for (int i = 1; i >= 0; i--) begin
      wr(7'h5F, 8'(i << 1));
      engine_event <= 16'h0100;
      @(posedge clock);
      engine_event <= 16'h0000;
      @(negedge clock);
      chk("irq pulse", 32'(i), 32'(second_irq_pin));
      @(negedge clock);
      chk("irq pulse end", 32'h0, 32'(second_irq_pin));
      @(posedge clock);
    end
    $display("test interrupt done");
    stop_test();
  end

  // a run that never ends is cut short here
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    $display("[FAIL] run expected end seen timeout");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
